// ### rtl/cirp_params.svh
/*
  Address map, reset values, slot count and frame/buffer sizes for the indirect register port.
  Assumes it is included by the design file only.
*/
`ifndef CIRP_PARAMS_SVH
`define CIRP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Direct addresses on the host port.
// ----------------------------------------------------------------------------
`define CIRP_DADDR_INDEX      3'h0
`define CIRP_DADDR_DATA       3'h2
`define CIRP_DADDR_FRAME      3'h3

// ----------------------------------------------------------------------------
// Indirect addresses.
// ----------------------------------------------------------------------------
`define CIRP_IA_TIMEOUT_MASK_2         16'h0e12
`define CIRP_IA_TIMEOUT_MASK_3         16'h0e13
`define CIRP_IA_TIMEOUT_MASK_4         16'h0e14
`define CIRP_IA_STRAP         16'h0e80
`define CIRP_IA_STRAP_LAST    16'h0e82
`define CIRP_IA_PSTATE        16'h0e90
`define CIRP_IA_RQOS          16'h0ea0
`define CIRP_IA_CPUQ_A        16'h0ea8
`define CIRP_IA_CPUQ_B        16'h0ea9
`define CIRP_IA_UPQ_A         16'h0eaa
`define CIRP_IA_UPQ_B         16'h0eab
`define CIRP_IA_CLASS         16'h0eac
`define CIRP_IA_BIRQ          16'h0ead
`define CIRP_IA_QCS           16'h0eb0
`define CIRP_IA_QALL          16'h0eba
`define CIRP_IA_BIST0         16'h0ebb
`define CIRP_IA_BIST1         16'h0ebc
`define CIRP_IA_BMCTL         16'h0ebd
`define CIRP_IA_BPRST         16'h0ec0
`define CIRP_IA_HEAD_LO       16'h0ec1
`define CIRP_IA_HEAD_HI       16'h0ec2
`define CIRP_IA_TAIL_LO       16'h0ec3
`define CIRP_IA_TAIL_HI       16'h0ec4
`define CIRP_IA_CNT_LO        16'h0ec5
`define CIRP_IA_CNT_HI        16'h0ec6
`define CIRP_IA_RLS_CTRL      16'h0ec7
`define CIRP_IA_RLS_INFO      16'h0ec8
`define CIRP_IA_RLS_LAST      16'h0ecd
`define CIRP_IA_GCR           16'h0f00
`define CIRP_IA_DCR0          16'h0f01
`define CIRP_IA_DEVICE_CONTROL_1          16'h0f02
`define CIRP_IA_DEVICE_PORT_STATUS          16'h0f03
`define CIRP_IA_DATA_READBACK          16'h0f04
`define CIRP_IA_FIXED         16'h0fff

// ----------------------------------------------------------------------------
// Reset values and fixed read values.
// ----------------------------------------------------------------------------
`define CIRP_RST_ZERO         8'h00
`define CIRP_RST_BMCTL        8'h0f
`define CIRP_RST_CNT_HI       8'h06
`define CIRP_FIXED_VALUE      8'hda
`define CIRP_RD_UNMAPPED      8'h00

// ----------------------------------------------------------------------------
// Port slots and frame header.
// ----------------------------------------------------------------------------
`define CIRP_NSLOT            6
`define CIRP_HDR_WORDS        3'h4
`define CIRP_PAY_ALIGN        2'h3
`define CIRP_BUF_DEPTH        2

`endif

// ### rtl/cirp_pkg.sv
/*
  Types shared by the indirect register port.
  Assumes cirp_params.svh supplies the numbers.
*/
package cirp_pkg;
  // Frame path phase: header words, then payload words.
  typedef enum logic [0:0] {
    CIRP_HDR,
    CIRP_PAY
  } cirp_fphase_t;
  typedef logic [7:0] cirp_byte_t;
endpackage

// ### rtl/cirp_port.sv
/*
  Host parallel register port: index, indirect data and frame registers,
  plus the indirect status/control map behind them.
  Assumes a synchronous host bus on ref_clk, one access per strobe cycle,
  and status inputs from the switch core that are synchronous to ref_clk.
*/
`timescale 1ns/10ps
`include "cirp_params.svh"

// Behaviour
// - write-only 16-bit index at address 0
// - 8-bit read/write data at address 2
// - 16-bit frame register at address 3
// - first 8 bytes after reset are the status header
// - port state read-back at E90 plus n
// - queue status at EA0+n, EA8/9, EAA/B
// - writable queue control EB0+n, reset zero
// - head/tail pointers split low/high bytes
// - count high holds init start, reset 006
// - F04 read-back only, F03 writable zero reset
module cirp_port (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         host_cs,
  input  wire logic         host_we,
  input  wire logic [2:0]   host_addr,
  input  wire logic [15:0]  host_wdata,
  output logic      [15:0]  host_rdata,
  output logic              host_rvalid,
  output logic              host_ready,
  input  wire logic [47:0]  port_state_in,
  input  wire logic [31:0]  rport_queue_in,
  input  wire logic [31:0]  cpu_uplink_queue_in,
  input  wire logic [7:0]   class_status_in,
  input  wire logic [15:0]  selftest_in,
  input  wire logic [47:0]  release_info_in,
  input  wire logic [15:0]  device_ctrl_in,
  input  wire logic [7:0]   data_readback_in,
  input  wire logic [2:0]   strap_in,
  input  wire logic [15:0]  rx_frame_data,
  input  wire logic         rx_frame_valid,
  output logic              rx_frame_ready,
  output logic      [15:0]  tx_frame_data,
  output logic              tx_frame_valid,
  output logic              tx_frame_hdr,
  input  wire logic         tx_frame_ready,
  output logic              pay_misaligned,
  output logic      [15:0]  fcb_head,
  output logic      [15:0]  fcb_tail,
  output logic      [14:0]  fcb_count,
  output logic              fcb_init_start,
  output logic      [47:0]  queue_ctrl,
  output logic      [7:0]   global_ctrl,
  output logic      [7:0]   port_status_ctrl
);

  // --------------------------------------------------------------------------
  // Storage.
  // --------------------------------------------------------------------------
  logic [15:0]              index_reg;
  logic [7:0]               wr_regs_reg [0:18];
  logic [7:0]               qcs_reg [0:`CIRP_NSLOT-1];
  logic [2:0]               strap_reg;
  logic                     strap_done_reg;
  logic [15:0]              buf_reg [0:`CIRP_BUF_DEPTH-1];
  logic                     bhdr_reg [0:`CIRP_BUF_DEPTH-1];
  logic                     wr_ptr_reg;
  logic                     rd_ptr_reg;
  logic [1:0]               cnt_reg;
  logic [2:0]               hdr_cnt_reg;
  logic [1:0]               pay_cnt_reg;
  cirp_pkg::cirp_fphase_t   phase_reg;

  logic                     acc_data;
  logic                     acc_frame;
  logic                     push;
  logic                     pop;
  logic [7:0]               ind_rdata;
  logic [4:0]               wsel;
  logic                     wsel_ok;
  logic [2:0]               slot;
  logic                     slot_ok;

  // Index of a writable register in the flat bank; invalid codes return 0/0.
  function automatic logic [5:0] cirp_wmap(input logic [15:0] a);
    logic [5:0] r;
    r = 6'h00;
    unique case (a)
      `CIRP_IA_TIMEOUT_MASK_2:    r = {1'b1, 5'd0};
      `CIRP_IA_TIMEOUT_MASK_3:    r = {1'b1, 5'd1};
      `CIRP_IA_TIMEOUT_MASK_4:    r = {1'b1, 5'd2};
      `CIRP_IA_BIRQ:     r = {1'b1, 5'd3};
      `CIRP_IA_QALL:     r = {1'b1, 5'd4};
      `CIRP_IA_BMCTL:    r = {1'b1, 5'd5};
      `CIRP_IA_BPRST:    r = {1'b1, 5'd6};
      `CIRP_IA_HEAD_LO:  r = {1'b1, 5'd7};
      `CIRP_IA_HEAD_HI:  r = {1'b1, 5'd8};
      `CIRP_IA_TAIL_LO:  r = {1'b1, 5'd9};
      `CIRP_IA_TAIL_HI:  r = {1'b1, 5'd10};
      `CIRP_IA_CNT_LO:   r = {1'b1, 5'd11};
      `CIRP_IA_CNT_HI:   r = {1'b1, 5'd12};
      `CIRP_IA_RLS_CTRL: r = {1'b1, 5'd13};
      `CIRP_IA_GCR:      r = {1'b1, 5'd14};
      `CIRP_IA_DEVICE_PORT_STATUS:     r = {1'b1, 5'd15};
      default:           r = 6'h00;
    endcase
    return r;
  endfunction

  // Port slot of a per-port address: ports 0..3 -> 0..3, 8 -> 4, 9 -> 5.
  function automatic logic [3:0] cirp_slot(input logic [15:0] a, input logic [15:0] base);
    logic [15:0] d;
    d = a - base;
    if (a < base) begin
      return 4'h0;
    end else if (d < 16'h0004) begin
      return {1'b1, d[2:0]};
    end else if (d == 16'h0008) begin
      return {1'b1, 3'd4};
    end else if (d == 16'h0009) begin
      return {1'b1, 3'd5};
    end
    return 4'h0;
  endfunction

  assign acc_data  = host_cs && (host_addr == `CIRP_DADDR_DATA);
  assign acc_frame = host_cs && (host_addr == `CIRP_DADDR_FRAME);
  assign {wsel_ok, wsel} = cirp_wmap(index_reg);
  assign {slot_ok, slot} = cirp_slot(index_reg, `CIRP_IA_QCS);

  // --------------------------------------------------------------------------
  // Index register.
  // --------------------------------------------------------------------------
  // The index only moves on a host write; reads of address 0 return zero.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_reg <= 16'h0000;
    end else if (host_cs && host_we && host_addr == `CIRP_DADDR_INDEX) begin
      index_reg <= host_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Writable indirect registers.
  // --------------------------------------------------------------------------
  // Writes land on whatever the last index write selected.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 19; i++) begin
        wr_regs_reg[i] <= `CIRP_RST_ZERO;
      end
      wr_regs_reg[5]  <= `CIRP_RST_BMCTL;
      wr_regs_reg[12] <= `CIRP_RST_CNT_HI;
    end else if (acc_data && host_we && wsel_ok) begin
      wr_regs_reg[wsel] <= host_wdata[7:0];
    end
  end

  // Per-port queue control slots, cleared at reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CIRP_NSLOT; i++) begin
        qcs_reg[i] <= `CIRP_RST_ZERO;
      end
    end else if (acc_data && host_we && slot_ok) begin
      qcs_reg[slot] <= host_wdata[7:0];
    end
  end

  // Strap pins are caught once, one clock after reset release.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg      <= 3'h0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_reg      <= strap_in;
      strap_done_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Indirect read decode.
  // --------------------------------------------------------------------------
  always_comb begin
    logic [3:0]  ps;
    logic [3:0]  qs;
    logic [15:0] off;
    ps  = cirp_slot(index_reg, `CIRP_IA_PSTATE);
    qs  = cirp_slot(index_reg, `CIRP_IA_RQOS);
    off = index_reg - `CIRP_IA_RLS_INFO;
    ind_rdata = `CIRP_RD_UNMAPPED;
    if (wsel_ok) begin
      ind_rdata = wr_regs_reg[wsel];
    end else if (slot_ok) begin
      ind_rdata = qcs_reg[slot];
    end else if (ps[3]) begin
      ind_rdata = port_state_in[ps[2:0]*8 +: 8];
    end else if (qs[3] && qs[2:0] < 3'd4) begin
      ind_rdata = rport_queue_in[qs[1:0]*8 +: 8];
    end else if (index_reg >= `CIRP_IA_CPUQ_A && index_reg <= `CIRP_IA_UPQ_B) begin
      ind_rdata = cpu_uplink_queue_in[index_reg[1:0]*8 +: 8];
    end else if (index_reg >= `CIRP_IA_RLS_INFO && index_reg <= `CIRP_IA_RLS_LAST) begin
      ind_rdata = release_info_in[off[2:0]*8 +: 8];
    end else if (index_reg >= `CIRP_IA_STRAP && index_reg <= `CIRP_IA_STRAP_LAST) begin
      ind_rdata = {7'h00, strap_reg[index_reg[1:0]]};
    end else begin
      unique case (index_reg)
        `CIRP_IA_CLASS: ind_rdata = class_status_in;
        `CIRP_IA_BIST0: ind_rdata = selftest_in[7:0];
        `CIRP_IA_BIST1: ind_rdata = selftest_in[15:8];
        `CIRP_IA_DCR0:  ind_rdata = device_ctrl_in[7:0];
        `CIRP_IA_DEVICE_CONTROL_1:  ind_rdata = device_ctrl_in[15:8];
        `CIRP_IA_DATA_READBACK:  ind_rdata = data_readback_in;
        `CIRP_IA_FIXED: ind_rdata = `CIRP_FIXED_VALUE;
        default:        ind_rdata = `CIRP_RD_UNMAPPED;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Host read answer and ready.
  // --------------------------------------------------------------------------
  // Reads answer one cycle after the strobe; a frame read with rx_frame_valid high takes rx_frame_data and pulses rx_frame_ready.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata  <= 16'h0000;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_cs && !host_we;
      if (acc_data && !host_we) begin
        host_rdata <= {8'h00, ind_rdata};
      end else if (acc_frame && !host_we) begin
        host_rdata <= rx_frame_valid ? rx_frame_data : 16'h0000;
      end else if (host_cs && !host_we) begin
        host_rdata <= 16'h0000;
      end
    end
  end

  // Host may write a frame word only while the buffer has room.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_ready     <= 1'b0;
      rx_frame_ready <= 1'b0;
    end else begin
      host_ready     <= (cnt_reg + 2'(push) - 2'(pop)) < 2'(`CIRP_BUF_DEPTH);
      rx_frame_ready <= 1'b0;
      if (acc_frame && !host_we && rx_frame_valid) begin
        rx_frame_ready <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Host-to-switch frame buffer, two entries.
  // --------------------------------------------------------------------------
  // A write into a full buffer is dropped; the host must watch host_ready.
  assign push = acc_frame && host_we && (cnt_reg < 2'(`CIRP_BUF_DEPTH));
  assign pop  = tx_frame_valid && tx_frame_ready;

  // First four words after reset are the status header; all later words are payload.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg   <= cirp_pkg::CIRP_HDR;
      hdr_cnt_reg <= 3'h0;
      pay_cnt_reg <= 2'h0;
    end else if (push) begin
      if (phase_reg == cirp_pkg::CIRP_HDR) begin
        hdr_cnt_reg <= hdr_cnt_reg + 3'h1;
        if (hdr_cnt_reg + 3'h1 == `CIRP_HDR_WORDS) begin
          phase_reg   <= cirp_pkg::CIRP_PAY;
          pay_cnt_reg <= 2'h0;
        end
      end else begin
        pay_cnt_reg <= pay_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      if (push) begin
        buf_reg[wr_ptr_reg]  <= host_wdata;
        bhdr_reg[wr_ptr_reg] <= (phase_reg == cirp_pkg::CIRP_HDR);
        wr_ptr_reg           <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
    end
  end

  // Output stage of the buffer is registered from the next occupancy.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_frame_valid <= 1'b0;
      tx_frame_data  <= 16'h0000;
      tx_frame_hdr   <= 1'b0;
    end else begin
      tx_frame_valid <= (cnt_reg + 2'(push) - 2'(pop)) != 2'h0;
      if (!pop && cnt_reg != 2'h0) begin
        tx_frame_data <= buf_reg[rd_ptr_reg];
        tx_frame_hdr  <= bhdr_reg[rd_ptr_reg];
      end else if (pop && cnt_reg == 2'h2) begin
        tx_frame_data <= buf_reg[!rd_ptr_reg];
        tx_frame_hdr  <= bhdr_reg[!rd_ptr_reg];
      end else begin
        tx_frame_data <= host_wdata;
        tx_frame_hdr  <= (phase_reg == cirp_pkg::CIRP_HDR);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control outputs.
  // --------------------------------------------------------------------------
  // Payload alignment flag: high while payload is not a whole 8-byte unit.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pay_misaligned   <= 1'b0;
      fcb_head         <= 16'h0000;
      fcb_tail         <= 16'h0000;
      fcb_count        <= 15'h0000;
      fcb_init_start   <= 1'b0;
      global_ctrl      <= 8'h00;
      port_status_ctrl <= 8'h00;
      queue_ctrl       <= 48'h0;
    end else begin
      pay_misaligned   <= (phase_reg == cirp_pkg::CIRP_PAY) && (pay_cnt_reg != 2'h0);
      fcb_head         <= {wr_regs_reg[8], wr_regs_reg[7]};
      fcb_tail         <= {wr_regs_reg[10], wr_regs_reg[9]};
      fcb_count        <= {wr_regs_reg[12][6:0], wr_regs_reg[11]};
      fcb_init_start   <= wr_regs_reg[12][7];
      global_ctrl      <= wr_regs_reg[14];
      port_status_ctrl <= wr_regs_reg[15];
      for (int i = 0; i < `CIRP_NSLOT; i++) begin
        queue_ctrl[i*8 +: 8] <= qcs_reg[i];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  AST_INDEX_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_cs && host_we && host_addr == `CIRP_DADDR_INDEX |=> index_reg == $past(host_wdata))
    else $error("Index register did not take write.");
  AST_DATA_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    acc_data && !host_we |=> host_rvalid && host_rdata[15:8] == 8'h00)
    else $error("Data read answer malformed.");
  // Write then read of the same indirect register, back to back.
  sequence cirp_ind_write_s;
    acc_data && host_we && wsel_ok;
  endsequence
  sequence cirp_ind_read_s;
    acc_data && !host_we && $stable(index_reg);
  endsequence
  AST_RMW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cirp_ind_write_s ##1 cirp_ind_read_s
      |=> host_rdata[7:0] == $past(host_wdata[7:0], 2))
    else $error("Indirect read did not return written value.");
  AST_FRAME_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    push && cnt_reg == 2'h0 && !tx_frame_valid |=> tx_frame_valid && tx_frame_data == $past(host_wdata))
    else $error("Frame word not forwarded.");
  AST_HDR_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    push && phase_reg == cirp_pkg::CIRP_HDR && hdr_cnt_reg == (`CIRP_HDR_WORDS - 3'h1)
      |=> phase_reg == cirp_pkg::CIRP_PAY)
    else $error("Header did not end after four words.");
  AST_CNT_HI_RST: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> wr_regs_reg[12] == `CIRP_RST_CNT_HI)
    else $error("Count high reset value wrong.");
  AST_DATA_READBACK_RO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    acc_data && !host_we && index_reg == `CIRP_IA_DATA_READBACK |=> host_rdata[7:0] == $past(data_readback_in))
    else $error("Data read-back mismatch.");
  AST_PSTATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    acc_data && !host_we && index_reg == `CIRP_IA_PSTATE |=> host_rdata[7:0] == $past(port_state_in[7:0]))
    else $error("Port state read-back mismatch.");
  AST_NO_OVERFLOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_reg <= 2'(`CIRP_BUF_DEPTH))
    else $error("Frame buffer overflow.");

endmodule

// ### tb/cirp_host_model.sv
/*
  Host CPU model for the parallel register port: single accesses and frame words.
  Assumes the caller sits on a falling edge of ref_clk when it calls a task.
*/
`timescale 1ns/10ps
module cirp_host_model (
  input  wire logic        ref_clk,
  output logic             host_cs,
  output logic             host_we,
  output logic [2:0]       host_addr,
  output logic [15:0]      host_wdata,
  input  wire logic [15:0] host_rdata,
  input  wire logic        host_rvalid,
  input  wire logic        host_ready
);
  // Idle bus at time zero.
  initial begin
    host_cs = 1'b0;
    host_we = 1'b0;
    host_addr = 3'h0;
    host_wdata = 16'h0000;
  end

  // One strobe cycle; the answer is taken on the next falling edge.
  task automatic acc(input logic we, input logic [2:0] a, input logic [15:0] d,
                     output logic [15:0] rd, output logic rv);
    host_cs = 1'b1;
    host_we = we;
    host_addr = a;
    host_wdata = d;
    @(negedge ref_clk);
    rd = host_rdata;
    rv = host_rvalid;
  endtask

  // Released lines flip, so a stale value can never look like a fresh one.
  task automatic idle();
    host_cs = 1'b0;
    host_addr = ~host_addr;
    host_wdata = ~host_wdata;
    @(negedge ref_clk);
  endtask

  // Frame word: honour the lagging ready flag, so wait one edge first.
  task automatic fw(input logic [15:0] d);
    logic [15:0] r;
    logic        v;
    @(negedge ref_clk);
    for (int i = 0; i < 50 && !host_ready; i++) @(negedge ref_clk);
    acc(1'b1, 3'h3, d, r, v);
    idle();
  endtask
endmodule

// ### tb/cirp_port_bench.sv
/*
  Self-checking bench for the indirect register port.
  Assumes the host model drives the bus and this module plays the switch side.
*/
`timescale 1ns/10ps
module cirp_port_bench;
  typedef struct packed {logic [15:0] ia; logic wr; logic [7:0] wd; logic [7:0] ex;} cirp_row_t;
  logic        ref_clk = 1'b0, rst_n = 1'b0, rx_frame_valid = 1'b0, tx_frame_ready = 1'b0, sink_run = 1'b0;
  logic        host_cs, host_we, host_rvalid, host_ready, rx_frame_ready, tx_frame_valid, tx_frame_hdr;
  logic        pay_misaligned, fcb_init_start, rv;
  logic [2:0]  host_addr, strap_in = 3'h5;
  logic [15:0] host_wdata, host_rdata, tx_frame_data, fcb_head, fcb_tail, rd;
  logic [15:0] rx_frame_data = 16'hbee0, selftest_in = 16'h5150, device_ctrl_in = 16'h7170;
  logic [14:0] fcb_count;
  logic [47:0] queue_ctrl, port_state_in = 48'h1514_1312_1110, release_info_in = 48'h6564_6362_6160;
  logic [31:0] rport_queue_in = 32'h2322_2120, cpu_uplink_queue_in = 32'h3332_3130;
  logic [7:0]  global_ctrl, port_status_ctrl, class_status_in = 8'h40, data_readback_in = 8'h80;
  logic [16:0] txq[$];
  int          n_errors = 0, n_checks = 0, n_rx = 0, n0;
  cirp_row_t   rows [32] = '{
    '{16'h0ead, 0, 8'h00, 8'h00}, '{16'h0eb0, 0, 8'h00, 8'h00}, '{16'h0eb9, 0, 8'h00, 8'h00},
    '{16'h0ebd, 0, 8'h00, 8'h0f}, '{16'h0ec6, 0, 8'h00, 8'h06}, '{16'h0f03, 0, 8'h00, 8'h00},
    '{16'h0fff, 0, 8'h00, 8'hda}, '{16'h0e80, 0, 8'h00, 8'h01}, '{16'h0e90, 0, 8'h00, 8'h10},
    '{16'h0e98, 0, 8'h00, 8'h14}, '{16'h0e99, 0, 8'h00, 8'h15}, '{16'h0ea0, 0, 8'h00, 8'h20},
    '{16'h0ea3, 0, 8'h00, 8'h23}, '{16'h0ea8, 0, 8'h00, 8'h30}, '{16'h0eab, 0, 8'h00, 8'h33},
    '{16'h0eac, 0, 8'h00, 8'h40}, '{16'h0ebc, 0, 8'h00, 8'h51}, '{16'h0ecd, 0, 8'h00, 8'h65},
    '{16'h0f02, 0, 8'h00, 8'h71}, '{16'h0f04, 1, 8'hff, 8'h80}, '{16'h0e91, 1, 8'hff, 8'h11},
    '{16'h0e94, 0, 8'h00, 8'h00}, '{16'h0e14, 1, 8'hc3, 8'hc3}, '{16'h0eb0, 1, 8'ha5, 8'ha5},
    '{16'h0eb9, 1, 8'h5a, 8'h5a}, '{16'h0ec1, 1, 8'h34, 8'h34}, '{16'h0ec2, 1, 8'h12, 8'h12},
    '{16'h0ec4, 1, 8'h9a, 8'h9a}, '{16'h0ec5, 1, 8'h78, 8'h78}, '{16'h0ec6, 1, 8'h85, 8'h85},
    '{16'h0f00, 1, 8'h66, 8'h66}, '{16'h0f03, 1, 8'h3c, 8'h3c}};

  cirp_port cirp_port_i (.ref_clk, .rst_n, .host_cs, .host_we, .host_addr, .host_wdata, .host_rdata,
    .host_rvalid, .host_ready, .port_state_in, .rport_queue_in, .cpu_uplink_queue_in, .class_status_in,
    .selftest_in, .release_info_in, .device_ctrl_in, .data_readback_in, .strap_in, .rx_frame_data,
    .rx_frame_valid, .rx_frame_ready, .tx_frame_data, .tx_frame_valid, .tx_frame_hdr, .tx_frame_ready,
    .pay_misaligned, .fcb_head, .fcb_tail, .fcb_count, .fcb_init_start, .queue_ctrl, .global_ctrl,
    .port_status_ctrl);
  cirp_host_model cirp_host_model_i (.ref_clk, .host_cs, .host_we, .host_addr, .host_wdata, .host_rdata,
    .host_rvalid, .host_ready);

  // Clock, plus a sink that stalls every other cycle while it runs.
  always #2.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) tx_frame_ready <= sink_run & ~tx_frame_ready;
  always @(posedge ref_clk) begin
    if (tx_frame_valid && tx_frame_ready) txq.push_back({tx_frame_hdr, tx_frame_data});
    if (rx_frame_ready) n_rx++;
  end

  // ----------------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Index, optional data write, data read back to back.
  task automatic rdi(input logic [15:0] ia, input logic wr, input logic [7:0] wd, output logic [15:0] v);
    cirp_host_model_i.acc(1'b1, 3'h0, ia, v, rv);
    if (wr) cirp_host_model_i.acc(1'b1, 3'h2, {8'h00, wd}, v, rv);
    cirp_host_model_i.acc(1'b0, 3'h2, 16'h0000, v, rv);
    cirp_host_model_i.idle();
    chk({15'h0000, rv}, 16'h0001);
    chk({15'h0000, host_rvalid}, 16'h0000);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the run needs a few thousand cycles at most.
  initial begin
    #100us;
    n_errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------------
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    chk({fcb_init_start, fcb_count}, 16'h0600);
    cirp_host_model_i.acc(1'b0, 3'h0, 16'h0000, rd, rv);
    cirp_host_model_i.idle();
    chk(rd, 16'h0000);
    foreach (rows[i]) begin
      rdi(rows[i].ia, rows[i].wr, rows[i].wd, rd);
      chk(rd, {8'h00, rows[i].ex});
    end
    @(negedge ref_clk);
    chk(fcb_head, 16'h1234);
    chk(fcb_tail, 16'h9a00);
    chk({fcb_init_start, fcb_count}, 16'h8578);
    chk({queue_ctrl[47:40], queue_ctrl[7:0]}, 16'h5aa5);
    chk({global_ctrl, port_status_ctrl}, 16'h663c);
    // Frame out: two words into a stalled sink fill the buffer.
    for (int k = 0; k < 2; k++) cirp_host_model_i.fw(16'ha000 + k[15:0]);
    repeat (2) @(negedge ref_clk);
    chk({15'h0000, host_ready}, 16'h0000);
    sink_run = 1'b1;
    for (int k = 2; k < 8; k++) cirp_host_model_i.fw(16'ha000 + k[15:0]);
    repeat (20) @(negedge ref_clk);
    chk(16'(txq.size()), 16'h0008);
    for (int k = 0; k < 8; k++) begin
      chk(txq[k][15:0], 16'ha000 + k[15:0]);
      chk({15'h0000, txq[k][16]}, {15'h0000, k < 4});
    end
    chk({15'h0000, pay_misaligned}, 16'h0000);
    cirp_host_model_i.fw(16'ha008);
    repeat (4) @(negedge ref_clk);
    chk({15'h0000, pay_misaligned}, 16'h0001);
    // Three words back to back into a stalled sink: the third is dropped.
    sink_run = 1'b0;
    repeat (4) @(negedge ref_clk);
    n0 = txq.size();
    for (int k = 0; k < 3; k++) cirp_host_model_i.acc(1'b1, 3'h3, 16'hc000 + k[15:0], rd, rv);
    cirp_host_model_i.idle();
    chk({15'h0000, host_ready}, 16'h0000);
    sink_run = 1'b1;
    repeat (20) @(negedge ref_clk);
    chk(16'(txq.size() - n0), 16'h0002);
    // Frame in: empty source reads zero, a valid word is consumed once.
    cirp_host_model_i.acc(1'b0, 3'h3, 16'h0000, rd, rv);
    chk(rd, 16'h0000);
    rx_frame_valid = 1'b1;
    cirp_host_model_i.acc(1'b0, 3'h3, 16'h0000, rd, rv);
    cirp_host_model_i.idle();
    rx_frame_valid = 1'b0;
    chk(rd, 16'hbee0);
    chk(16'(n_rx), 16'h0001);
    // Second reset in mid-run returns the written registers to their reset values.
    rst_n = 1'b0;
    @(negedge ref_clk);
    chk(fcb_head, 16'h0000);
    rst_n = 1'b1;
    rdi(16'h0ec1, 1'b0, 8'h00, rd);
    chk(rd, 16'h0000);
    report_and_stop();
  end
endmodule
